// ===== core/display_lane_mux_fifo_ctrl.v
`timescale 1ns/100ps
`include "display_lane_mux_defines.vh"


module display_lane_mux_fifo_ctrl (
  input  wire                     clock,               // 200 MHz clock.
  input  wire                     rst_n,               // Sync reset, low.
  input  wire                     wb_cyc_i,            // Bus cycle.
  input  wire                     wb_stb_i,            // Bus strobe.
  input  wire                     wb_we_i,             // Bus write.
  input  wire [7:0]               wb_adr_i,            // Byte address.
  input  wire [3:0]               wb_sel_i,            // Byte enables.
  input  wire [31:0]              wb_dat_i,            // Write data.
  output reg  [31:0]              wb_dat_o,            // Read data.
  output reg                      wb_ack_o,            // Acknowledge.
  input  wire [`LANE_GROUP_W-1:0] ch1_data,            // Channel 1 data.
  input  wire [`LANE_GROUP_W-1:0] ch1_mirror_data,     // Mirrored ch 1.
  input  wire [`LANE_GROUP_W-1:0] ch2_data,            // Channel 2 data.
  input  wire [`LANE_GROUP_W-1:0] ch2_mirror_data,     // Mirrored ch 2.
  input  wire [`LANE_GROUP_W-1:0] pcie_lanes0_3_data,  // PCIe lanes 0-3.
  input  wire [`LANE_GROUP_W-1:0] pcie_lanes4_7_data,  // PCIe lanes 4-7.
  output reg  [`LANE_GROUP_W-1:0] phy_lanes0_3_data,   // PHY lanes 0-3.
  output reg  [`LANE_GROUP_W-1:0] phy_lanes4_7_data,   // PHY lanes 4-7.
  output reg                      fifo1_write_clock_select, // Link clk 0.
  output reg                      fifo2_write_clock_select, // Link clk 1.
  output reg  [2:0]               fifo1_read_clock_select,  // {A,B,C}.
  output reg  [2:0]               fifo2_read_clock_select,  // {A,B,C}.
  output reg  [2:0]               lanes0_3_clock_source,    // {A,B,C}.
  output reg  [2:0]               lanes4_7_clock_source,    // {A,B,C}.
  output reg  [2:0]               lanes8_15_clock_source,   // {A,B,C}.
  output reg                      pll_a_power_up,      // PLL A running.
  output reg                      pll_b_power_up,      // PLL B running.
  output reg                      pll_c_power_up,      // PLL C running.
  output reg  [3:0]               lane_group_a_common_mode_high, // Lanes.
  output reg                      lane_group_a_transmit_on, // Tx 0-7.
  output reg  [3:0]               lane_group_c_common_mode_high, // Lanes.
  output reg                      lane_group_c_transmit_on, // Tx 12-15.
  output wire                     fifo1_write_side_reset, // FIFO 1 reset.
  output wire                     fifo1_read_side_reset,  // FIFO 1 reset.
  output wire                     fifo2_write_side_reset, // FIFO 2 reset.
  output wire                     fifo2_read_side_reset,  // FIFO 2 reset.
  output reg                      dual_link_enable,    // Dual-link mode.
  output reg                      path0_receiver_detect_flag, // Path 0.
  output reg                      path1_receiver_detect_flag  // Path 1.
);

  // ****************************************************************
  // Decoding helpers.
  // ****************************************************************
  function [2:0] decode_read_clock;
    input [2:0] code;
    begin
      case (code)
        `RCLK_PLL_A: decode_read_clock = `SEL_PLL_A;
        `RCLK_PLL_B: decode_read_clock = `SEL_PLL_B;
        `RCLK_PLL_C: decode_read_clock = `SEL_PLL_C;
        default:     decode_read_clock = `SEL_NONE;
      endcase
    end
  endfunction

  function [2:0] decode_tx_source;
    input [1:0] code;
    begin
      case (code)
        `TXSRC_PLL_A: decode_tx_source = `SEL_PLL_A;
        `TXSRC_PLL_B: decode_tx_source = `SEL_PLL_B;
        `TXSRC_PLL_C: decode_tx_source = `SEL_PLL_C;
        default:      decode_tx_source = `SEL_NONE;
      endcase
    end
  endfunction

  function [31:0] merge_bytes;
    input [31:0] old_value;
    input [31:0] new_value;
    input [3:0]  sel;
    integer      i;
    begin
      merge_bytes = old_value;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge_bytes[i*8 +: 8] = new_value[i*8 +: 8];
        end
      end
    end
  endfunction

  // ****************************************************************
  // Wishbone slave and configuration registers.
  // ****************************************************************
  reg  [31:0] phy_clock_source_select_q;
  reg  [31:0] lane_traffic_select_q;
  reg  [31:0] display_mux_fifo_control_q;
  reg  [31:0] pll_a_lane_control_q;
  reg  [31:0] pll_b_control_q;
  reg  [31:0] pll_c_lane_control_q;
  reg  [31:0] read_data_d;
  reg  [3:0]  status_d;
  wire [5:0]  index;
  wire        request;
  wire        write_req;
  wire        clear_flag0;
  wire        clear_flag1;

  assign index     = wb_adr_i[7:2];
  assign request   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign write_req = request & wb_we_i;
  assign clear_flag0 = write_req & (index == `IDX_PATH_STATUS) &
                       wb_sel_i[0] & wb_dat_i[`STAT_FLAG0];
  assign clear_flag1 = write_req & (index == `IDX_PATH_STATUS) &
                       wb_sel_i[0] & wb_dat_i[`STAT_FLAG1];

  always @* begin
    status_d                    = 4'h0;
    status_d[`STAT_FLAG0]       = path0_receiver_detect_flag;
    status_d[`STAT_FLAG1]       = path1_receiver_detect_flag;
    status_d[`STAT_F1_IN_RESET] = fifo1_write_side_reset |
                                  fifo1_read_side_reset;
    status_d[`STAT_F2_IN_RESET] = fifo2_write_side_reset |
                                  fifo2_read_side_reset;
    case (index)
      `IDX_PHY_CLOCK_SOURCE: read_data_d = phy_clock_source_select_q;
      `IDX_LANE_TRAFFIC:     read_data_d = lane_traffic_select_q;
      `IDX_DISPLAY_MUX_FIFO: read_data_d = display_mux_fifo_control_q;
      `IDX_PLL_A_LANE:       read_data_d = pll_a_lane_control_q;
      `IDX_PLL_B:            read_data_d = pll_b_control_q;
      `IDX_PLL_C_LANE:       read_data_d = pll_c_lane_control_q;
      `IDX_PATH_STATUS:      read_data_d = {28'h0000000, status_d};
      default:               read_data_d = 32'h0000_0000;
    endcase
  end

  // Every access is answered one cycle after it is seen, mapped or not,
  // so a stray address cannot hang the bus.
  always @(posedge clock) begin
    if (!rst_n) begin
      wb_ack_o                   <= 1'b0;
      wb_dat_o                   <= 32'h0000_0000;
      phy_clock_source_select_q  <= `REG_RESET_VALUE;
      lane_traffic_select_q      <= `REG_RESET_VALUE;
      display_mux_fifo_control_q <= `REG_RESET_VALUE;
      pll_a_lane_control_q       <= `REG_RESET_VALUE;
      pll_b_control_q            <= `REG_RESET_VALUE;
      pll_c_lane_control_q       <= `REG_RESET_VALUE;
    end else begin
      wb_ack_o <= request;
      if (request && !wb_we_i) begin
        wb_dat_o <= read_data_d;
      end
      if (write_req) begin
        case (index)
          `IDX_PHY_CLOCK_SOURCE: phy_clock_source_select_q <=
            merge_bytes(phy_clock_source_select_q, wb_dat_i, wb_sel_i);
          `IDX_LANE_TRAFFIC: lane_traffic_select_q <=
            merge_bytes(lane_traffic_select_q, wb_dat_i, wb_sel_i);
          `IDX_DISPLAY_MUX_FIFO: display_mux_fifo_control_q <=
            merge_bytes(display_mux_fifo_control_q, wb_dat_i, wb_sel_i);
          `IDX_PLL_A_LANE: pll_a_lane_control_q <=
            merge_bytes(pll_a_lane_control_q, wb_dat_i, wb_sel_i);
          `IDX_PLL_B: pll_b_control_q <=
            merge_bytes(pll_b_control_q, wb_dat_i, wb_sel_i);
          `IDX_PLL_C_LANE: pll_c_lane_control_q <=
            merge_bytes(pll_c_lane_control_q, wb_dat_i, wb_sel_i);
          default: ;
        endcase
      end
    end
  end

  // ****************************************************************
  // FIFO reset holding.
  // ****************************************************************
  fifo_reset_hold u_f1_write_hold (
    .clock   (clock),
    .rst_n   (rst_n),
    .request (display_mux_fifo_control_q[`MUX_F1_WRITE_RESET]),
    .hold    (fifo1_write_side_reset)
  );

  fifo_reset_hold u_f1_read_hold (
    .clock   (clock),
    .rst_n   (rst_n),
    .request (display_mux_fifo_control_q[`MUX_F1_READ_RESET]),
    .hold    (fifo1_read_side_reset)
  );

  fifo_reset_hold u_f2_write_hold (
    .clock   (clock),
    .rst_n   (rst_n),
    .request (display_mux_fifo_control_q[`MUX_F2_WRITE_RESET]),
    .hold    (fifo2_write_side_reset)
  );

  fifo_reset_hold u_f2_read_hold (
    .clock   (clock),
    .rst_n   (rst_n),
    .request (display_mux_fifo_control_q[`MUX_F2_READ_RESET]),
    .hold    (fifo2_read_side_reset)
  );

  // ****************************************************************
  // Receiver-detect flags.
  // ****************************************************************
  reg  f1_in_reset_q;
  reg  f2_in_reset_q;
  wire f1_in_reset;
  wire f2_in_reset;
  wire f1_released;
  wire f2_released;

  assign f1_in_reset = fifo1_write_side_reset | fifo1_read_side_reset;
  assign f2_in_reset = fifo2_write_side_reset | fifo2_read_side_reset;
  // A path counts as configured when its reset ends with a write clock
  // and a valid read clock chosen; the flag then stays until cleared.
  assign f1_released = f1_in_reset_q & ~f1_in_reset &
                       fifo1_write_clock_select &
                       (fifo1_read_clock_select != `SEL_NONE);
  assign f2_released = f2_in_reset_q & ~f2_in_reset &
                       fifo2_write_clock_select &
                       (fifo2_read_clock_select != `SEL_NONE);

  always @(posedge clock) begin
    if (!rst_n) begin
      f1_in_reset_q              <= 1'b0;
      f2_in_reset_q              <= 1'b0;
      path0_receiver_detect_flag <= 1'b0;
      path1_receiver_detect_flag <= 1'b0;
    end else begin
      f1_in_reset_q <= f1_in_reset;
      f2_in_reset_q <= f2_in_reset;
      // Set wins over a clear in the same cycle.
      if (f1_released) begin
        path0_receiver_detect_flag <= 1'b1;
      end else if (clear_flag0) begin
        path0_receiver_detect_flag <= 1'b0;
      end
      if (f2_released) begin
        path1_receiver_detect_flag <= 1'b1;
      end else if (clear_flag1) begin
        path1_receiver_detect_flag <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Clock selection, PLL power and transmitter controls.
  // ****************************************************************
  wire [31:0] mux_ctl;
  wire [31:0] phy_ctl;

  assign mux_ctl = display_mux_fifo_control_q;
  assign phy_ctl = phy_clock_source_select_q;

  always @(posedge clock) begin
    if (!rst_n) begin
      fifo1_write_clock_select      <= 1'b0;
      fifo2_write_clock_select      <= 1'b0;
      fifo1_read_clock_select       <= `SEL_NONE;
      fifo2_read_clock_select       <= `SEL_NONE;
      lanes0_3_clock_source         <= `SEL_NONE;
      lanes4_7_clock_source         <= `SEL_NONE;
      lanes8_15_clock_source        <= `SEL_NONE;
      pll_a_power_up                <= 1'b0;
      pll_b_power_up                <= 1'b0;
      pll_c_power_up                <= 1'b0;
      lane_group_a_common_mode_high <= 4'h0;
      lane_group_a_transmit_on      <= 1'b0;
      lane_group_c_common_mode_high <= 4'h0;
      lane_group_c_transmit_on      <= 1'b0;
      dual_link_enable              <= 1'b0;
    end else begin
      fifo1_write_clock_select <= mux_ctl[`MUX_F1_WRITE_CLOCK];
      fifo2_write_clock_select <= mux_ctl[`MUX_F2_WRITE_CLOCK];
      fifo1_read_clock_select  <=
        decode_read_clock(phy_ctl[`PHY_F1_READ_CLOCK]);
      fifo2_read_clock_select  <=
        decode_read_clock(phy_ctl[`PHY_F2_READ_CLOCK]);
      lanes0_3_clock_source    <=
        decode_tx_source(phy_ctl[`PHY_LANES0_3_SRC]);
      lanes4_7_clock_source    <=
        decode_tx_source(phy_ctl[`PHY_LANES4_7_SRC]);
      lanes8_15_clock_source   <=
        decode_tx_source(phy_ctl[`PHY_LANES8_15_SRC]);
      // With the pair override clear, PLLs A and B follow their own bits; PLL C ORs its bit with MUX_PLL_C_ON.
      pll_a_power_up <= mux_ctl[`MUX_PLL_PAIR_ON] |
                        pll_a_lane_control_q[`PLL_POWER_UP];
      pll_b_power_up <= mux_ctl[`MUX_PLL_PAIR_ON] |
                        pll_b_control_q[`PLL_POWER_UP];
      pll_c_power_up <= mux_ctl[`MUX_PLL_C_ON] |
                        pll_c_lane_control_q[`PLL_POWER_UP];
      // Pacing of these bits against PLL lock is left to software.
      lane_group_a_common_mode_high <=
        pll_a_lane_control_q[`PLL_COMMON_MODE];
      lane_group_a_transmit_on <= pll_a_lane_control_q[`PLL_TRANSMIT_ON];
      lane_group_c_common_mode_high <=
        pll_c_lane_control_q[`PLL_COMMON_MODE];
      lane_group_c_transmit_on <=
        pll_c_lane_control_q[`PLL_TRANSMIT_ON];
      dual_link_enable <= mux_ctl[`MUX_DUAL_LINK];
    end
  end

  // ****************************************************************
  // Transmit lane data muxing.
  // ****************************************************************
  // Only a transmit path exists; no receive data comes back here.
  reg [`LANE_GROUP_W-1:0] stage0_ch1;
  reg [`LANE_GROUP_W-1:0] stage0_ch2;
  reg [`LANE_GROUP_W-1:0] stage1_lanes0_3;
  reg [`LANE_GROUP_W-1:0] stage1_lanes4_7;

  always @* begin
    stage0_ch1 = mux_ctl[`MUX_S0_CH1] ? ch1_mirror_data
                                      : ch1_data;
    stage0_ch2 = mux_ctl[`MUX_S0_CH2] ? ch2_mirror_data
                                      : ch2_data;
    stage1_lanes0_3 = mux_ctl[`MUX_S1_LANES0_3] ? stage0_ch2
                                                : stage0_ch1;
    stage1_lanes4_7 = mux_ctl[`MUX_S1_LANES4_7] ? stage0_ch1
                                                : stage0_ch2;
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      phy_lanes0_3_data <= {`LANE_GROUP_W{1'b0}};
      phy_lanes4_7_data <= {`LANE_GROUP_W{1'b0}};
    end else begin
      // Display and PCIe traffic never mix on a lane group.
      phy_lanes0_3_data <= lane_traffic_select_q[`TRAFFIC_LANES0_3] ?
                           stage1_lanes0_3 : pcie_lanes0_3_data;
      phy_lanes4_7_data <= lane_traffic_select_q[`TRAFFIC_LANES4_7] ?
                           stage1_lanes4_7 : pcie_lanes4_7_data;
    end
  end

endmodule

// ===== core/display_lane_mux_defines.vh
`ifndef DISPLAY_LANE_MUX_DEFINES_VH
`define DISPLAY_LANE_MUX_DEFINES_VH

// ****************************************************************
// Register indices; the byte address is the index times four.
// ****************************************************************
`define IDX_PHY_CLOCK_SOURCE  6'h07
`define IDX_LANE_TRAFFIC      6'h27
`define IDX_DISPLAY_MUX_FIFO  6'h28
`define IDX_PLL_A_LANE        6'h29
`define IDX_PLL_B             6'h2a
`define IDX_PLL_C_LANE        6'h2b
`define IDX_PATH_STATUS       6'h30
`define REG_RESET_VALUE       32'h0000_0000

// ****************************************************************
// Display mux and FIFO control fields.
// ****************************************************************
`define MUX_PLL_PAIR_ON       0
`define MUX_PLL_C_ON          1
`define MUX_F1_WRITE_RESET    2
`define MUX_F1_READ_RESET     3
`define MUX_F2_WRITE_RESET    4
`define MUX_F2_READ_RESET     5
`define MUX_F1_WRITE_CLOCK    12
`define MUX_F2_WRITE_CLOCK    13
`define MUX_S0_CH1            16
`define MUX_S0_CH2            17
`define MUX_S1_LANES0_3       18
`define MUX_S1_LANES4_7       19
`define MUX_DUAL_LINK         23

// ****************************************************************
// Clock source fields and their codes.
// ****************************************************************
`define PHY_LANES0_3_SRC      21:20
`define PHY_LANES4_7_SRC      23:22
`define PHY_LANES8_15_SRC     25:24
`define PHY_F1_READ_CLOCK     28:26
`define PHY_F2_READ_CLOCK     31:29
`define TXSRC_PLL_A           2'h0
`define TXSRC_PLL_C           2'h2
`define TXSRC_PLL_B           2'h3
`define RCLK_PLL_C            3'h1
`define RCLK_PLL_B            3'h2
`define RCLK_PLL_A            3'h4
`define SEL_PLL_A             3'h4
`define SEL_PLL_B             3'h2
`define SEL_PLL_C             3'h1
`define SEL_NONE              3'h0

// ****************************************************************
// Lane traffic, PLL lane control and status fields.
// ****************************************************************
`define TRAFFIC_LANES0_3      4
`define TRAFFIC_LANES4_7      5
`define PLL_COMMON_MODE       3:0
`define PLL_TRANSMIT_ON       4
`define PLL_POWER_UP          26
`define STAT_FLAG0            0
`define STAT_FLAG1            1
`define STAT_F1_IN_RESET      2
`define STAT_F2_IN_RESET      3

// ****************************************************************
// Timing and widths.
// ****************************************************************
`define CLK_PERIOD_NS         5
`define FIFO_RESET_MIN_NS     100
`define FIFO_RESET_MIN_CYC    \
  ((`FIFO_RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CNT_W            8
`define LANE_GROUP_W          40

`endif

// ===== core/fifo_reset_hold.v
`timescale 1ns/100ps
`include "display_lane_mux_defines.vh"

module fifo_reset_hold (
  input  wire clock,   // Core register clock.
  input  wire rst_n,   // Synchronous reset, active low.
  input  wire request, // Reset level written by software.
  output reg  hold     // Reset level driven to the FIFO side.
);

  localparam integer           MIN_CYC_FULL = `FIFO_RESET_MIN_CYC;
  localparam [`HOLD_CNT_W-1:0] MIN_CYC      = MIN_CYC_FULL[`HOLD_CNT_W-1:0];

  reg [`HOLD_CNT_W-1:0] count_q;
  reg [`HOLD_CNT_W-1:0] count_d;
  reg                   hold_d;

  // A reset pulse shorter than the minimum is stretched so the FIFO
  // always sees a full reset, even if software releases it early.
  always @* begin
    hold_d  = request | (hold & (count_q < MIN_CYC));
    count_d = count_q;
    if (!hold) begin
      count_d = {`HOLD_CNT_W{1'b0}};
    end else if (count_q < MIN_CYC) begin
      count_d = count_q + 1'b1;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      hold    <= 1'b0;
      count_q <= {`HOLD_CNT_W{1'b0}};
    end else begin
      hold    <= hold_d;
      count_q <= count_d;
    end
  end

endmodule

// ===== tb/display_lane_mux_fifo_ctrl_asserts.sv
`timescale 1ns/100ps
`include "display_lane_mux_defines.vh"

module display_lane_mux_fifo_ctrl_asserts (
  input wire       clock,                     // Clock.
  input wire       rst_n,                     // Reset, low.
  input wire       wb_cyc_i,                  // Cycle.
  input wire       wb_stb_i,                  // Strobe.
  input wire       wb_ack_o,                  // Acknowledge.
  input wire       fifo1_write_side_reset,    // FIFO 1 reset.
  input wire       fifo2_read_side_reset,     // FIFO 2 reset.
  input wire       fifo1_write_clock_select,  // Write clock.
  input wire [2:0] fifo1_read_clock_select,   // Read clock.
  input wire [2:0] lanes0_3_clock_source,     // Lane clock.
  input wire [2:0] lanes4_7_clock_source,     // Lane clock.
  input wire       dual_link_enable,          // Mode.
  input wire       path0_receiver_detect_flag // Flag.
);
  logic [7:0] hold_q;
  logic       rst_q;
  default clocking @(posedge clock); endclocking
  // The edge after release is skipped, so history checks never see the
  // jump that reset itself makes on the outputs.
  default disable iff (!rst_n || !rst_q);
  // Counts how long the FIFO 1 reset has stood, saturating so it never wraps.
  always @(posedge clock) begin
    rst_q <= rst_n;
    if (!rst_n || !fifo1_write_side_reset) hold_q <= 8'h00;
    else if (hold_q != 8'hff) hold_q <= hold_q + 8'h01;
  end
  a_ack_single_pulse : assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stood longer than one cycle");
  a_ack_answers_req : assert property
    ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_f1_reset_hold : assert property
    ($fell(fifo1_write_side_reset) |-> hold_q >= `FIFO_RESET_MIN_CYC)
    else $error("FIFO 1 reset released too early");
  a_f2_reset_held : assert property
    ($rose(fifo2_read_side_reset) |=> fifo2_read_side_reset[*8])
    else $error("FIFO 2 reset dropped early");
  a_rclk_one_hot : assert property ($onehot0(fifo1_read_clock_select))
    else $error("FIFO 1 read clock not one-hot");
  a_lane_src_hot : assert property
    ($onehot0(lanes0_3_clock_source) && $onehot0(lanes4_7_clock_source))
    else $error("lane clock source not one-hot");
  a_wclk_by_bus : assert property
    ($changed(fifo1_write_clock_select) |-> $past(wb_ack_o))
    else $error("write clock changed without a write");
  a_dual_by_bus : assert property
    ($changed(dual_link_enable) |-> $past(wb_ack_o))
    else $error("dual link changed without a write");
  a_flag_cause : assert property ($rose(path0_receiver_detect_flag) |->
    $past(fifo1_write_clock_select) && !$past(fifo1_write_side_reset))
    else $error("flag set without a configured path");
  a_flag_sticky : assert property
    ($fell(path0_receiver_detect_flag) |-> wb_ack_o)
    else $error("flag cleared without a write");
endmodule

bind display_lane_mux_fifo_ctrl display_lane_mux_fifo_ctrl_asserts i_chk (
  .clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .fifo1_write_side_reset,
  .fifo2_read_side_reset, .fifo1_write_clock_select, .fifo1_read_clock_select,
  .lanes0_3_clock_source, .lanes4_7_clock_source, .dual_link_enable,
  .path0_receiver_detect_flag);

// ===== tb/display_lane_mux_fifo_ctrl_test.sv
`timescale 1ns/100ps
`include "display_lane_mux_defines.vh"

module display_lane_mux_fifo_ctrl_test;
  logic clock, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd_q;
  logic [39:0] ch1_data, ch1_mirror_data, ch2_data, ch2_mirror_data;
  logic [39:0] pcie_lanes0_3_data, pcie_lanes4_7_data, m1, m2, e03, e47;
  logic [39:0] phy_lanes0_3_data, phy_lanes4_7_data;
  logic fifo1_write_clock_select, fifo2_write_clock_select, dual_link_enable;
  logic [2:0] fifo1_read_clock_select, fifo2_read_clock_select, er, es;
  logic [2:0] lanes0_3_clock_source, lanes4_7_clock_source;
  logic [2:0] lanes8_15_clock_source;
  logic pll_a_power_up, pll_b_power_up, pll_c_power_up;
  logic [3:0] lane_group_a_common_mode_high, lane_group_c_common_mode_high;
  logic lane_group_a_transmit_on, lane_group_c_transmit_on;
  logic fifo1_write_side_reset, fifo1_read_side_reset;
  logic fifo2_write_side_reset, fifo2_read_side_reset;
  logic path0_receiver_detect_flag, path1_receiver_detect_flag;
  logic [5:0] ridx [7] = '{6'h07, 6'h27, 6'h28, 6'h29, 6'h2a, 6'h2b, 6'h30};
  int error_cnt, n_tests, k;

  display_lane_mux_fifo_ctrl i_dut (.clock, .rst_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ch1_data,
    .ch1_mirror_data, .ch2_data, .ch2_mirror_data, .pcie_lanes0_3_data,
    .pcie_lanes4_7_data, .phy_lanes0_3_data, .phy_lanes4_7_data,
    .fifo1_write_clock_select, .fifo2_write_clock_select,
    .fifo1_read_clock_select, .fifo2_read_clock_select, .lanes0_3_clock_source,
    .lanes4_7_clock_source, .lanes8_15_clock_source, .pll_a_power_up,
    .pll_b_power_up, .pll_c_power_up, .lane_group_a_common_mode_high,
    .lane_group_a_transmit_on, .lane_group_c_common_mode_high,
    .lane_group_c_transmit_on, .fifo1_write_side_reset, .fifo1_read_side_reset,
    .fifo2_write_side_reset, .fifo2_read_side_reset, .dual_link_enable,
    .path0_receiver_detect_flag, .path1_receiver_detect_flag);

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ******************************************************************
  // Bus and check tasks.
  // ******************************************************************
  task automatic results;
    $display("Checks %0d, errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until ack is seen high; read data is taken there.
  task automatic bus(input logic we, input logic [5:0] idx,
                     input logic [3:0] sel, input logic [31:0] d);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= sel;
    wb_dat_i <= d;
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    rd_q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    bus(1'b1, idx, 4'hf, d);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 4'hf, 32'h0000_0000);
    chk({8'h00, rd_q}, {8'h00, exp});
  endtask
  // Outputs lag the register by one cycle; two edges leave margin.
  task automatic settle;
    repeat (2) @(posedge clock);
    #1;
  endtask

  initial begin
    repeat (30000) @(posedge clock);
    error_cnt++;
    results;
  end

  initial begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {ch1_data, ch1_mirror_data, ch2_data, ch2_mirror_data} = '0;
    {pcie_lanes0_3_data, pcie_lanes4_7_data} = '0;
    error_cnt = 0;
    n_tests = 0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    for (k = 0; k < 7; k++) rd(ridx[k], `REG_RESET_VALUE);
    for (k = 0; k < 6; k++) wr(ridx[k], 32'ha1c3_0f00 + k);
    for (k = 0; k < 6; k++) rd(ridx[k], 32'ha1c3_0f00 + k);
    wr(6'h3f, 32'hffff_ffff);
    rd(6'h3f, 32'h0000_0000);
    bus(1'b1, 6'h07, 4'h2, 32'hffff_ffff);
    rd(6'h07, 32'ha1c3_ff00);
    for (k = 0; k < 8; k++) begin
      wr(6'h07, {k[2:0], k[2:0], {3{k[1:0]}}, 20'h00000});
      settle;
      er = (k == 1 || k == 2 || k == 4) ? k[2:0] : `SEL_NONE;
      es = k[1:0] == 2'b00 ? `SEL_PLL_A : k[1:0] == 2'b11 ? `SEL_PLL_B :
           k[1:0] == 2'b10 ? `SEL_PLL_C : `SEL_NONE;
      chk(fifo1_read_clock_select, er);
      chk(fifo2_read_clock_select, er);
      chk(lanes0_3_clock_source, es);
      chk(lanes4_7_clock_source, es);
      chk(lanes8_15_clock_source, es);
    end
    wr(6'h28, 32'h0080_3003);
    settle;
    chk({fifo2_write_clock_select, fifo1_write_clock_select}, 2'h3);
    chk({dual_link_enable, pll_a_power_up, pll_b_power_up}, 3'h7);
    wr(6'h28, 32'h0000_0000);
    wr(6'h29, 32'h0400_0000);
    wr(6'h2a, 32'h0000_0000);
    wr(6'h2b, 32'h0400_0000);
    repeat (6000) @(posedge clock);
    chk({pll_a_power_up, pll_b_power_up, pll_c_power_up}, 3'h5);
    for (k = 1; k <= 4; k++) begin
      wr(6'h2b, 32'h0400_0000 | ((1 << k) - 1));
      settle;
      chk(lane_group_c_common_mode_high, (1 << k) - 1);
    end
    repeat (8) @(posedge clock);
    wr(6'h2b, 32'h0400_001f);
    settle;
    chk({pll_c_power_up, lane_group_c_transmit_on}, 2'h3);
    wr(6'h29, 32'h0400_000f);
    wr(6'h29, 32'h0000_000f);
    wr(6'h2a, 32'h0000_0000);
    settle;
    chk({lane_group_a_transmit_on, pll_a_power_up, pll_b_power_up},
        3'h0);
    chk(lane_group_a_common_mode_high, 4'hf);
    for (k = 0; k < 32; k++) begin
      @(posedge clock);
      ch1_data <= {8'h11, k};
      ch1_mirror_data <= {8'h12, k};
      ch2_data <= {8'h21, k};
      ch2_mirror_data <= {8'h22, k};
      pcie_lanes0_3_data <= {8'h31, k};
      pcie_lanes4_7_data <= {8'h32, k};
      wr(6'h28, {12'h000, k[3:0], 16'h0000});
      wr(6'h27, {26'h0, k[4], k[4], 4'h0});
      settle;
      m1 = k[0] ? ch1_mirror_data : ch1_data;
      m2 = k[1] ? ch2_mirror_data : ch2_data;
      e03 = !k[4] ? pcie_lanes0_3_data : k[2] ? m2 : m1;
      e47 = !k[4] ? pcie_lanes4_7_data : k[3] ? m1 : m2;
      chk(phy_lanes0_3_data, e03);
      chk(phy_lanes4_7_data, e47);
    end
    wr(6'h07, 32'h5000_0000);
    wr(6'h28, 32'h0000_303c);
    wr(6'h28, 32'h0000_3000);
    #1;
    chk({fifo1_write_side_reset, fifo1_read_side_reset,
         fifo2_write_side_reset, fifo2_read_side_reset}, 4'hf);
    rd(6'h30, 32'h0000_000c);
    repeat (`FIFO_RESET_MIN_CYC + 4) @(posedge clock);
    chk({path1_receiver_detect_flag, path0_receiver_detect_flag},
        2'h3);
    rd(6'h30, 32'h0000_0003);
    wr(6'h30, 32'h0000_0003);
    rd(6'h30, 32'h0000_0000);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rd(6'h28, `REG_RESET_VALUE);
    results;
  end
endmodule
